// File: logic/tsp_port.sv
// three-wire serial slave port core with received-byte fifo
// What this block does
// - chip select high holds interface reset
// - sample data on serial clock rise
// - change read data on clock fall
// - bytes eight bits, msb first, framed
// - subaddress bit 7 direction, low bits ignored
// - accept only subaddress code 01
// - write: next byte is control byte
// - control byte: continue and select bits
// - read returns the temperature byte, repeated while selected
// - drive data right after subaddress
// - release data line when select rises
`timescale 1ns/1ns
`include "tsp_regs.svh"
module tsp_port
(
   input  wire logic       i_ref_clk,        // 10 MHz system clock
   input  wire logic       i_reset,          // async reset, active high
   input  wire logic       i_cs_n,           // chip select pin, active low
   input  wire logic       i_sclk,           // serial clock pin
   input  wire logic       i_sdio,           // data pin input
   output logic            o_sdio,           // data pin output
   output logic            o_sdio_oe,        // high while driving data pin
   input  wire logic [7:0] i_temperature_byte, // live temperature value
   output logic            o_byte_valid,     // received byte available
   input  wire logic       i_byte_ready,     // consumer takes byte
   output logic [7:0]      o_byte_data,      // received command or display byte
   output logic            o_command_or_display_select, // 1 display, 0 command
   output logic            o_overflow        // byte lost, fifo full
);
   // synchroniser chains
   logic [1:0] cs_sync;                    // chip select sync
   logic [1:0] clk_sync;                   // serial clock sync
   logic [1:0] dio_sync;                   // data sync
   logic       clk_prev;                   // last synced clock level
   logic       rise;                       // rising edge seen
   logic       fall;                       // falling edge seen
   logic       cs_idle;                    // chip select inactive
   // framing state
   tsp_pkg::tsp_state_t state;             // transfer phase
   tsp_pkg::tsp_state_t next_state;        // phase after a byte
   logic [2:0] bit_cnt;                    // bits of current byte
   logic [7:0] shift_in;                   // receive shifter
   logic [7:0] rx_byte;                    // byte just completed
   logic       byte_done;                  // last bit sampled now
   logic       more_control_bytes_flag;    // more control bytes follow
   logic       command_or_display_select;  // route of data bytes
   logic [7:0] shift_out;                  // transmit shifter
   logic       load_read;                  // read access accepted
   tsp_fifo_if fq ();                      // core to fifo stream
   logic [8:0] fifo_word;                  // fifo output word

   // two flops per pin before any logic reads them
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         cs_sync  <= 2'h3;
         clk_sync <= 2'h0;
         dio_sync <= 2'h0;
      end
      else
      begin
         cs_sync  <= {cs_sync[0], i_cs_n};
         clk_sync <= {clk_sync[0], i_sclk};
         dio_sync <= {dio_sync[0], i_sdio};
      end
   end

   // edge finder on the synced clock
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         clk_prev <= 1'b0;
      end
      else
      begin
         clk_prev <= clk_sync[1];
      end
   end

   assign cs_idle   = cs_sync[1];
   assign rise      = clk_sync[1] && !clk_prev && !cs_idle;
   assign fall      = !clk_sync[1] && clk_prev && !cs_idle;
   assign rx_byte   = {shift_in[6:0], dio_sync[1]};
   assign byte_done = rise && (bit_cnt == 3'h7);

   // receive shifter and bit counter
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         bit_cnt  <= 3'h0;
         shift_in <= 8'h00;
      end
      else if (cs_idle)
      begin
         bit_cnt  <= 3'h0;
         shift_in <= 8'h00;
      end
      else if (rise)
      begin
         shift_in <= rx_byte;
         bit_cnt  <= bit_cnt + 3'h1;
      end
   end

   // phase decision at the end of each byte
   always_comb
   begin
      next_state = state;
      load_read  = 1'b0;
      case (state)
         tsp_pkg::TSP_IDLE,
         tsp_pkg::TSP_SUBADDR:
         begin
            if (rx_byte[`TSP_SUB_ADDR_HI:`TSP_SUB_ADDR_LO] != `TSP_SUB_ADDR_MATCH)
            begin
               next_state = tsp_pkg::TSP_IGNORE;
            end
            else if (rx_byte[`TSP_SUB_DIR_BIT])
            begin
               next_state = tsp_pkg::TSP_READ;
               load_read  = 1'b1;
            end
            else
            begin
               next_state = tsp_pkg::TSP_CONTROL;
            end
         end
         tsp_pkg::TSP_CONTROL:
         begin
            // every control byte is followed by data
            next_state = tsp_pkg::TSP_DATA;
         end
         tsp_pkg::TSP_DATA:
         begin
            if (more_control_bytes_flag)
            begin
               next_state = tsp_pkg::TSP_CONTROL;
            end
            else
            begin
               // data keeps flowing until select rises
               next_state = tsp_pkg::TSP_DATA;
            end
         end
         tsp_pkg::TSP_READ,
         tsp_pkg::TSP_IGNORE:
         begin
            next_state = state;
         end
         default:
         begin
            next_state = tsp_pkg::TSP_IGNORE;
         end
      endcase
   end

   // phase register
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         state <= tsp_pkg::TSP_IDLE;
      end
      else if (cs_idle)
      begin
         state <= tsp_pkg::TSP_IDLE;
      end
      else if (byte_done)
      begin
         state <= next_state;
      end
   end

   // control byte fields
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         more_control_bytes_flag   <= 1'b0;
         command_or_display_select <= 1'b0;
      end
      else if (cs_idle)
      begin
         more_control_bytes_flag   <= 1'b0;
         command_or_display_select <= 1'b0;
      end
      else if (byte_done && state == tsp_pkg::TSP_CONTROL)
      begin
         more_control_bytes_flag   <= rx_byte[`TSP_CTL_MORE_BIT];
         command_or_display_select <= rx_byte[`TSP_CTL_SELECT_BIT];
      end
   end

   // every byte in the data phase is offered to the fifo; while control
   // bytes continue, that phase lasts one byte only
   assign fq.valid = byte_done && (state == tsp_pkg::TSP_DATA);
   assign fq.data  = {command_or_display_select, rx_byte};

   // lost byte flag, sticky until select rises
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_overflow <= 1'b0;
      end
      else if (fq.valid && !fq.ready)
      begin
         o_overflow <= 1'b1;
      end
      else if (cs_idle)
      begin
         o_overflow <= 1'b0;
      end
   end

   // read data driver
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         shift_out <= 8'h00;
         o_sdio    <= 1'b0;
         o_sdio_oe <= 1'b0;
      end
      else if (cs_idle)
      begin
         o_sdio_oe <= 1'b0;
         o_sdio    <= 1'b0;
      end
      else if (byte_done && load_read)
      begin
         shift_out <= i_temperature_byte;
         o_sdio    <= i_temperature_byte[7];
         o_sdio_oe <= 1'b1;
      end
      else if (fall && state == tsp_pkg::TSP_READ)
      begin
         o_sdio    <= shift_out[7];
         shift_out <= {shift_out[6:0], shift_out[7]};
      end
   end

   // the fall after the last subaddress bit shows the msb again, so
   // every fall rotates by one and the byte repeats while selected

   tsp_fifo #(
      .WIDTH (`TSP_FIFO_WIDTH),
      .DEPTH (`TSP_FIFO_DEPTH)
   ) u_fifo (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .wr        (fq.snk),
      .o_valid   (o_byte_valid),
      .i_ready   (i_byte_ready),
      .o_data    (fifo_word)
   );

   // registered outputs straight from the fifo stage
   assign o_byte_data                 = fifo_word[7:0];
   assign o_command_or_display_select = fifo_word[8];
endmodule

// File: logic/tsp_regs.svh
// size and field constants for the three-wire serial slave port
`ifndef TSP_REGS_SVH
`define TSP_REGS_SVH
`define TSP_BYTE_BITS        8
`define TSP_FIFO_DEPTH       16
`define TSP_FIFO_WIDTH       9
`define TSP_SUB_DIR_BIT      7
`define TSP_SUB_ADDR_HI      6
`define TSP_SUB_ADDR_LO      5
`define TSP_SUB_ADDR_MATCH   2'h1
`define TSP_CTL_MORE_BIT     7
`define TSP_CTL_SELECT_BIT   6
`endif

// File: logic/tsp_pkg.sv
// types for the three-wire serial slave port
package tsp_pkg;
   typedef enum logic [2:0]
   {
      TSP_IDLE,
      TSP_SUBADDR,
      TSP_CONTROL,
      TSP_DATA,
      TSP_READ,
      TSP_IGNORE
   } tsp_state_t;
endpackage

// File: logic/tsp_fifo_if.sv
// valid/ready stream between the port core and its output fifo
`timescale 1ns/1ns
interface tsp_fifo_if;
   logic       valid;  // word offered
   logic       ready;  // word accepted
   logic [8:0] data;   // select bit and byte
   modport src
   (
      output valid,
      output data,
      input  ready
   );
   modport snk
   (
      input  valid,
      input  data,
      output ready
   );
endinterface

// File: logic/tsp_fifo.sv
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ns
module tsp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
)
(
   input  wire logic             i_ref_clk,
   input  wire logic             i_reset,
   tsp_fifo_if.snk               wr,
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic [WIDTH-1:0]      o_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];   // storage
   logic [AW-1:0]    wptr;          // write index
   logic [AW-1:0]    rptr;          // read index
   logic [AW:0]      count;         // words held
   logic             do_wr;         // push this cycle
   logic             do_rd;         // pop this cycle
   // honest full and empty drive the handshakes
   assign wr.ready = (count != DEPTH[AW:0]);
   assign do_wr    = wr.valid && wr.ready;
   assign do_rd    = o_valid && i_ready;
   // storage write
   always_ff @(posedge i_ref_clk)
   begin
      if (do_wr)
      begin
         mem[wptr] <= wr.data;
      end
   end
   // pointers and occupancy
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         wptr  <= '0;
         rptr  <= '0;
         count <= '0;
      end
      else
      begin
         if (do_wr)
         begin
            wptr <= wptr + 1'b1;
         end
         if (do_rd)
         begin
            rptr <= rptr + 1'b1;
         end
         count <= count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
      end
   end
   // registered output stage, refilled as soon as it drains
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_valid <= 1'b0;
         o_data  <= '0;
      end
      else if (!o_valid || i_ready)
      begin
         o_valid <= 1'b0;
         if (count != '0 && !(do_rd && count == {{AW{1'b0}}, 1'b1}))
         begin
            o_valid <= 1'b1;
            o_data  <= mem[rptr + {{(AW-1){1'b0}}, do_rd}];
         end
      end
   end
endmodule

// File: tb/tsp_port_chk.sv
// pin and stream assertions for the serial slave port
`timescale 1ns/1ns
module tsp_port_chk
(
   input wire logic       i_ref_clk,
   input wire logic       i_reset,
   input wire logic       i_cs_n,
   input wire logic       i_sclk,
   input wire logic       o_sdio,
   input wire logic       o_sdio_oe,
   input wire logic [7:0] i_temperature_byte,
   input wire logic       o_byte_valid,
   input wire logic       i_byte_ready,
   input wire logic [7:0] o_byte_data,
   input wire logic       o_command_or_display_select,
   input wire logic       o_overflow
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   // idle select keeps the port quiet
   property p_idle;
      i_cs_n [*5] |-> !o_sdio_oe && !o_overflow;
   endproperty
   a_idle: assert property (p_idle) else $error("drive while deselected");
   property p_start;
      $rose(o_sdio_oe) |-> !i_cs_n && i_sclk;
   endproperty
   a_start: assert property (p_start) else $error("drive start late");
   property p_msb;
      $rose(o_sdio_oe) |-> o_sdio == i_temperature_byte[7];
   endproperty
   a_msb: assert property (p_msb) else $error("first bit not msb");
   property p_fall;
      o_sdio_oe && $past(o_sdio_oe) && $changed(o_sdio) |-> !$past(i_sclk);
   endproperty
   a_fall: assert property (p_fall) else $error("data moved off fall");
   property p_hold;
      o_sdio_oe && !i_cs_n |=> o_sdio_oe;
   endproperty
   a_hold: assert property (p_hold) else $error("drive dropped in read");
   property p_release;
      $rose(i_cs_n) |-> ##[1:5] !o_sdio_oe;
   endproperty
   a_release: assert property (p_release) else $error("line not released");
   property p_stall;
      o_byte_valid && !i_byte_ready |=> o_byte_valid && $stable(o_byte_data)
         && $stable(o_command_or_display_select);
   endproperty
   a_stall: assert property (p_stall) else $error("byte changed while stalled");
   property p_sticky;
      o_overflow && !i_cs_n |=> o_overflow;
   endproperty
   a_sticky: assert property (p_sticky) else $error("overflow lost in frame");
   c_read: cover property ($rose(o_sdio_oe));
   c_pop: cover property (o_byte_valid && i_byte_ready);
   c_ovf: cover property ($rose(o_overflow));
endmodule
bind tsp_port tsp_port_chk tsp_port_chk_inst
(
   .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
   .o_sdio(o_sdio), .o_sdio_oe(o_sdio_oe), .i_temperature_byte(i_temperature_byte),
   .o_byte_valid(o_byte_valid), .i_byte_ready(i_byte_ready), .o_byte_data(o_byte_data),
   .o_command_or_display_select(o_command_or_display_select), .o_overflow(o_overflow)
);

// File: tb/tsp_host.sv
// behavioural bus master driving select, clock and data
`timescale 1ns/1ns
module tsp_host
(
   input  wire logic i_ref_clk,
   input  wire logic i_sdio,
   output logic      o_cs_n,
   output logic      o_sclk,
   output logic      o_sdio,
   output logic      o_sdio_oe
);
   initial
   begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_sdio = 1'b0;
      o_sdio_oe = 1'b1;
   end
   // half of the 800 ns link period
   task automatic half();
      repeat (4) @(negedge i_ref_clk);
   endtask
   task automatic start();
      o_cs_n = 1'b0;
      half();
   endtask
   // msb first, data set while clock low
   task automatic put_bits(input logic [7:0] b, input int n, input logic rel);
      for (int i = 7; i > 7 - n; i--)
      begin
         o_sclk = 1'b0;
         o_sdio = b[i];
         half();
         o_sclk = 1'b1;
         half();
         // hand over once last bit is taken
         if (i == 0 && rel)
            o_sdio_oe = 1'b0;
      end
   endtask
   // sample read bits just before each rise
   task automatic get_byte(output logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         o_sclk = 1'b0;
         half();
         b[i] = i_sdio;
         o_sclk = 1'b1;
         half();
      end
   endtask
   // close frame, then retake the line
   task automatic stop();
      o_sclk = 1'b0;
      half();
      o_cs_n = 1'b1;
      o_sdio_oe = 1'b1;
      half();
   endtask
endmodule

// File: tb/tb_tsp_port.sv
// self-checking bench for the serial slave port
`timescale 1ns/1ns
module tb_tsp_port;
   logic       i_ref_clk = 1'b0; // 10 MHz reference
   logic       i_reset = 1'b1;   // held at start
   logic [7:0] temp = 8'h00;     // temperature input
   logic       ready = 1'b0;     // consumer ready
   logic       flt = 1'b0;       // wobble on an undriven line
   logic       cs_n, sclk, h_sdio, h_oe, d_sdio, d_oe, valid, sel, ovf, wire_sdio;
   logic [7:0] data;
   int         err_total = 0;
   int         checks_done = 0;
   always #50 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) flt <= ~flt;
   // shared data line level
   assign wire_sdio = d_oe ? d_sdio : (h_oe ? h_sdio : flt);
   tsp_port tsp_port_inst
   (
      .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_cs_n(cs_n), .i_sclk(sclk),
      .i_sdio(wire_sdio), .o_sdio(d_sdio), .o_sdio_oe(d_oe), .i_temperature_byte(temp),
      .o_byte_valid(valid), .i_byte_ready(ready), .o_byte_data(data),
      .o_command_or_display_select(sel), .o_overflow(ovf)
   );
   tsp_host tsp_host_inst
   (
      .i_ref_clk(i_ref_clk), .i_sdio(wire_sdio), .o_cs_n(cs_n), .o_sclk(sclk),
      .o_sdio(h_sdio), .o_sdio_oe(h_oe)
   );
   task automatic chk8(input string w, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic chk1(input string w, input logic e, input logic g);
      chk8(w, {7'h00, e}, {7'h00, g});
   endtask
   task automatic wr(input logic [7:0] b);
      tsp_host_inst.put_bits(b, 8, 1'b0);
   endtask
   // take one byte from the fifo and judge it
   task automatic pop(input logic [7:0] e, input logic s);
      for (int n = 0; n < 60 && valid !== 1'b1; n++)
         @(negedge i_ref_clk);
      chk1("valid", 1'b1, valid);
      chk8("data", e, data);
      chk1("select", s, sel);
      ready = 1'b1;
      @(negedge i_ref_clk);
      ready = 1'b0;
   endtask
   task automatic t_write();
      tsp_host_inst.start();
      wr(8'h20);
      wr(8'h40);
      wr(8'hAB);
      wr(8'h5C);
      tsp_host_inst.stop();
      pop(8'hAB, 1'b1);
      pop(8'h5C, 1'b1);
   endtask
   // partial byte then a control chain
   task automatic t_chain();
      tsp_host_inst.start();
      tsp_host_inst.put_bits(8'h20, 4, 1'b0);
      tsp_host_inst.stop();
      tsp_host_inst.start();
      wr(8'h3F);
      wr(8'h80);
      wr(8'h12);
      wr(8'h40);
      wr(8'h34);
      tsp_host_inst.stop();
      pop(8'h12, 1'b0);
      pop(8'h34, 1'b1);
      chk1("valid", 1'b0, valid);
   endtask
   // foreign device codes on both directions
   task automatic t_bad();
      logic [1:0] c;
      for (int k = 0; k < 3; k++)
      begin
         c = (k == 0) ? 2'h0 : 2'(k + 1);
         tsp_host_inst.start();
         wr({1'b0, c, 5'h00});
         wr(8'h40);
         wr(8'h77);
         tsp_host_inst.stop();
         tsp_host_inst.start();
         wr({1'b1, c, 5'h00});
         chk1("drive", 1'b0, d_oe);
         tsp_host_inst.stop();
         chk1("valid", 1'b0, valid);
      end
   endtask
   // two reads of one value, second with junk low bits
   task automatic t_read(input logic [7:0] v);
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] c;
      temp = v;
      tsp_host_inst.start();
      tsp_host_inst.put_bits(8'hA0, 8, 1'b1);
      tsp_host_inst.get_byte(a);
      tsp_host_inst.get_byte(c);
      tsp_host_inst.stop();
      tsp_host_inst.start();
      tsp_host_inst.put_bits(8'hBF, 8, 1'b1);
      tsp_host_inst.get_byte(b);
      tsp_host_inst.stop();
      repeat (2) @(negedge i_ref_clk);
      chk1("release", 1'b0, d_oe);
      chk8("first read", v, a);
      chk8("second read", v, b);
      chk8("repeat byte", v, c);
   endtask
   // fill the fifo past full while the consumer stalls
   task automatic t_ovf();
      tsp_host_inst.start();
      wr(8'h20);
      wr(8'h40);
      for (int k = 0; k < 17; k++)
         wr(8'(k));
      chk1("overflow", 1'b1, ovf);
      tsp_host_inst.stop();
      chk1("overflow", 1'b0, ovf);
      for (int k = 0; k < 16; k++)
         pop(8'(k), 1'b1);
      chk1("valid", 1'b0, valid);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      i_reset = 1'b0;
      repeat (4) @(negedge i_ref_clk);
      t_write();
      t_chain();
      t_bad();
      t_read(8'hA5);
      t_read(8'h5A);
      t_ovf();
      tally_and_finish();
   end
   // watchdog well past the expected run
   initial
   begin
      #3_000_000;
      err_total++;
      tally_and_finish();
   end
endmodule
